// ### rims_pkg.sv
// constants shared by the mode-select block; no other assumptions.
package rims_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_DEVICE_STATUS = 8'h04;
  localparam logic [7:0] IDX_CSI_PLL_CONTROL   = 8'h1F;
  localparam logic [7:0] IDX_PORT_CFG0     = 8'h6D;
  localparam logic [7:0] IDX_PORT_CFG1     = 8'h6E;
  localparam logic [7:0] IDX_VC_REMAP0     = 8'h70;
  localparam logic [7:0] IDX_VC_REMAP1     = 8'h71;
  localparam logic [7:0] IDX_RAW_HDR0      = 8'h72;
  localparam logic [7:0] IDX_RAW_HDR1      = 8'h73;
  localparam logic [7:0] IDX_PORT_STS0     = 8'h74;
  localparam logic [7:0] IDX_PORT_STS1     = 8'h75;
  localparam int         SYNC_CLK_BIT      = 4;
  localparam int         STS_VIOL_BIT      = 9;
  localparam int         STS_OVF_BIT       = 10;
  localparam int         STS_FRM40_BIT     = 11;
  localparam int         CFG_RAW8_BIT      = 2;
  localparam int         CFG_RAW8_LSB_BIT  = 3;
  localparam logic [7:0] PORT_CFG_RST      = 8'h00;
  localparam logic [7:0] PLL_CTL_RST       = 8'h00;
  localparam logic [7:0] VC_REMAP_RST      = 8'hE4;
  localparam logic [7:0] RAW_HDR_RST       = 8'h2B;
  // input mode field encodings
  localparam logic [1:0] MODE_CSI          = 2'h0;
  localparam logic [1:0] MODE_RAW12_LF     = 2'h1;
  localparam logic [1:0] MODE_RAW12_HF     = 2'h2;
  localparam logic [1:0] MODE_RAW10        = 2'h3;
  // strap mode numbers
  localparam logic [2:0] STRAP_CSI_NSYNC   = 3'h0;
  localparam logic [2:0] STRAP_RAW12_LF    = 3'h1;
  localparam logic [2:0] STRAP_RAW12_HF    = 3'h2;
  localparam logic [2:0] STRAP_RAW10       = 3'h3;
  localparam logic [2:0] STRAP_CSI_SYNC    = 3'h4;
  // timing
  localparam int         CLK_HZ            = 50_000_000;
  localparam int         STRAP_WAIT_US     = 1000;
  localparam int         STRAP_WAIT_CYC    = STRAP_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int         SYNC_GAP_PCLK     = 10;
  // line rate figures, in thirds of the governing clock
  localparam logic [8:0] LR3_CSI_SYNC      = 9'h1E0; // 160x
  localparam logic [8:0] LR3_CSI_NSYNC     = 9'h0F0; // 80x
  localparam logic [8:0] LR3_RAW12_HF      = 9'h038; // 2/3 x 28
  localparam logic [8:0] LR3_RAW10         = 9'h02A; // 1/2 x 28
  localparam logic [8:0] LR3_RAW12_LF      = 9'h000;
  localparam logic [5:0] BC_MULT_SYNC      = 6'h02;
  localparam logic [5:0] BC_MBPS_NSYNC     = 6'h0A;
  localparam logic [7:0] PCLK_MULT_SYNC    = 8'h04;
  // output packet kinds
  typedef enum logic [2:0] {
    RIMS_PK_PAYLOAD = 3'h0,
    RIMS_PK_FS      = 3'h1,
    RIMS_PK_FE      = 3'h2,
    RIMS_PK_LS      = 3'h3,
    RIMS_PK_LE      = 3'h4,
    RIMS_PK_CSI     = 3'h5
  } rims_kind_e;
endpackage : rims_pkg

// ### rims_ser_model.sv
// remote serializer model: per-port link clock and frame word.
// assumes the bench sends one frame at a time on each port.
`timescale 1ns/10ps
module rims_ser_model (
  output logic [1:0]       forward_pixel_clock,
  output logic [1:0][39:0] rx_frame
);
  initial begin
    forward_pixel_clock = 2'h0;
    rx_frame            = {40'h55AA33CC0F, 40'hAA55CC33F0};
  end
  // clock stands still between frames; word inverts once its hold ends
  task automatic send(input int port, input logic [39:0] word);
    #3 rx_frame[port] = word;
    #40 forward_pixel_clock[port] = 1'b1;
    #80 forward_pixel_clock[port] = 1'b0;
    #40 rx_frame[port] = ~word;
  endtask : send
  // discrete sync bits beside the pixel word
  task automatic send_raw(input int port, input logic vs, input logic hs,
                          input logic [11:0] pix);
    send(port, {26'h0, vs, hs, pix});
  endtask : send_raw
endmodule : rims_ser_model

// ### rims_top.sv
// per-port receive input mode select with APB registers and packet build.
// assumes power_down_n, mode_strap and both link inputs are asynchronous
// pins; the strap arrives already digitised to a 3-bit level code.
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
module rims_top #(
  parameter int STRAP_WAIT = rims_pkg::STRAP_WAIT_CYC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              power_down_n,
  input  wire logic [2:0]        mode_strap,
  input  wire logic [1:0]        forward_pixel_clock,
  input  wire logic [1:0][39:0]  rx_frame,
  input  wire logic              tx_ready,
  output logic                   tx_valid,
  output logic                   tx_port,
  output logic      [2:0]        tx_kind,
  output logic      [1:0]        tx_vc,
  output logic      [5:0]        tx_dt,
  output logic      [31:0]       tx_data,
  output logic      [2:0]        strap_mode,
  output logic                   strap_done,
  output logic                   sync_clk_mode,
  output logic      [5:0]        back_rate,
  output logic      [7:0]        pix_clk_mult
);
  typedef struct packed {
    logic              pd_s1;
    logic              pd_s2;
    logic              pd_prev;
    logic [2:0]        st_s1;
    logic [2:0]        st_s2;
    logic [31:0]       wait_cnt;
    logic              waiting;
    logic              done;
    logic [2:0]        strap;
    logic              sync_clk;
    logic [7:0]        pll_ctl;
    logic [1:0][7:0]   cfg;
    logic [1:0][7:0]   remap;
    logic [1:0][7:0]   hdr;
    logic [1:0]        ck_s1;
    logic [1:0]        ck_s2;
    logic [1:0]        ck_prev;
    logic [1:0][39:0]  d_s1;
    logic [1:0][39:0]  d_s2;
    logic [1:0]        hs_prev;
    logic [1:0]        vs_prev;
    logic [1:0][3:0]   gap;
    logic [1:0]        viol;
    logic [1:0]        ovf;
    logic [1:0]        pv;
    logic [1:0][2:0]   pkind;
    logic [1:0][1:0]   pvc;
    logic [1:0][5:0]   pdt;
    logic [1:0][31:0]  pdat;
    logic              rr;
    logic              ov;
    logic              oport;
    logic [2:0]        okind;
    logic [1:0]        ovc;
    logic [5:0]        odt;
    logic [31:0]       odat;
    logic [31:0]       rdata;
    logic              err;
  } rims_state_s;

  rims_state_s state_reg;
  rims_state_s state_next;

  logic        setup;
  logic        wr;
  logic [7:0]  idx;
  logic        mapped;
  logic [31:0] rd_mux;

  assign setup  = psel && !penable;
  assign wr     = psel && penable && pwrite;
  assign idx    = paddr[9:2];
  assign pready = 1'b1;

  // line-rate figure per port mode, in thirds of its governing clock
  function automatic logic [8:0] rims_rate(input logic [1:0] m,
                                           input logic       sync);
    logic [8:0] r;
    r = rims_pkg::LR3_RAW12_LF;
    case (m)
      rims_pkg::MODE_CSI:      r = sync ? rims_pkg::LR3_CSI_SYNC
                                        : rims_pkg::LR3_CSI_NSYNC;
      rims_pkg::MODE_RAW12_HF: r = rims_pkg::LR3_RAW12_HF;
      rims_pkg::MODE_RAW10:    r = rims_pkg::LR3_RAW10;
      default:                 r = rims_pkg::LR3_RAW12_LF;
    endcase
    return r;
  endfunction : rims_rate

  always_comb begin
    logic [31:0] sts;
    sts    = 32'h0000_0000;
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (idx)
      rims_pkg::IDX_DEVICE_STATUS:
        rd_mux[rims_pkg::SYNC_CLK_BIT] = state_reg.sync_clk;
      rims_pkg::IDX_CSI_PLL_CONTROL: rd_mux[7:0] = state_reg.pll_ctl;
      rims_pkg::IDX_PORT_CFG0:   rd_mux[7:0] = state_reg.cfg[0];
      rims_pkg::IDX_PORT_CFG1:   rd_mux[7:0] = state_reg.cfg[1];
      rims_pkg::IDX_VC_REMAP0:   rd_mux[7:0] = state_reg.remap[0];
      rims_pkg::IDX_VC_REMAP1:   rd_mux[7:0] = state_reg.remap[1];
      rims_pkg::IDX_RAW_HDR0:    rd_mux[7:0] = state_reg.hdr[0];
      rims_pkg::IDX_RAW_HDR1:    rd_mux[7:0] = state_reg.hdr[1];
      rims_pkg::IDX_PORT_STS0, rims_pkg::IDX_PORT_STS1: begin
        sts[8:0] = rims_rate(state_reg.cfg[idx[0]][1:0],
                             state_reg.sync_clk);
        sts[rims_pkg::STS_VIOL_BIT]  = state_reg.viol[idx[0]];
        sts[rims_pkg::STS_OVF_BIT]   = state_reg.ovf[idx[0]];
        sts[rims_pkg::STS_FRM40_BIT] =
          (state_reg.cfg[idx[0]][1:0] == rims_pkg::MODE_CSI);
        rd_mux = sts;
      end
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    logic        pd_rise;
    logic        edge_seen;
    logic        hs;
    logic        vs;
    logic        sync_chg;
    logic [1:0]  m;
    logic [39:0] d;
    logic [1:0]  pick;
    logic        load;
    logic        take;
    state_next = state_reg;
    pd_rise    = 1'b0;
    edge_seen  = 1'b0;
    hs         = 1'b0;
    vs         = 1'b0;
    sync_chg   = 1'b0;
    m          = rims_pkg::MODE_CSI;
    d          = 40'h00_0000_0000;
    pick       = 2'h0;
    load       = 1'b0;
    take       = 1'b0;

    state_next.pd_s1   = power_down_n;
    state_next.pd_s2   = state_reg.pd_s1;
    state_next.pd_prev = state_reg.pd_s2;
    state_next.st_s1   = mode_strap;
    state_next.st_s2   = state_reg.st_s1;
    pd_rise = state_reg.pd_s2 && !state_reg.pd_prev;

    // strap timer restarts on each release; held off while powered down
    if (!state_reg.pd_s2) begin
      state_next.waiting  = 1'b0;
      state_next.wait_cnt = 32'h0000_0000;
      state_next.done     = 1'b0;
    end else if (pd_rise) begin
      state_next.waiting  = 1'b1;
      state_next.wait_cnt = 32'h0000_0000;
      state_next.done     = 1'b0;
    end else if (state_reg.waiting) begin
      state_next.wait_cnt = state_reg.wait_cnt + 32'h0000_0001;
      if (state_reg.wait_cnt == 32'(STRAP_WAIT - 1)) begin
        state_next.waiting = 1'b0;
        state_next.done    = 1'b1;
        state_next.strap   = state_reg.st_s2;
        // eight levels; unlisted ones fall back to CSI non-synchronous
        case (state_reg.st_s2)
          rims_pkg::STRAP_RAW12_LF: m = rims_pkg::MODE_RAW12_LF;
          rims_pkg::STRAP_RAW12_HF: m = rims_pkg::MODE_RAW12_HF;
          rims_pkg::STRAP_RAW10:    m = rims_pkg::MODE_RAW10;
          default:                  m = rims_pkg::MODE_CSI;
        endcase
        state_next.sync_clk =
          (state_reg.st_s2 == rims_pkg::STRAP_CSI_SYNC);
        state_next.pll_ctl[1:0] =
          {1'b0, (state_reg.st_s2 == rims_pkg::STRAP_CSI_SYNC)};
        state_next.cfg[0][1:0] = m;
        state_next.cfg[1][1:0] = m;
      end
    end

    // apb register writes; a later write beats the strap until release
    if (wr && pstrb[0]) begin
      case (idx)
        rims_pkg::IDX_CSI_PLL_CONTROL: begin
          state_next.pll_ctl  = pwdata[7:0];
          state_next.sync_clk = pwdata[0];
        end
        rims_pkg::IDX_PORT_CFG0: state_next.cfg[0]   = pwdata[7:0];
        rims_pkg::IDX_PORT_CFG1: state_next.cfg[1]   = pwdata[7:0];
        rims_pkg::IDX_VC_REMAP0: state_next.remap[0] = pwdata[7:0];
        rims_pkg::IDX_VC_REMAP1: state_next.remap[1] = pwdata[7:0];
        rims_pkg::IDX_RAW_HDR0:  state_next.hdr[0]   = pwdata[7:0];
        rims_pkg::IDX_RAW_HDR1:  state_next.hdr[1]   = pwdata[7:0];
        default: ;
      endcase
    end
    if (wr && pstrb[1]) begin
      for (int p = 0; p < 2; p++) begin
        if (idx == (rims_pkg::IDX_PORT_STS0 + 8'(p))) begin
          if (pwdata[rims_pkg::STS_VIOL_BIT]) state_next.viol[p] = 1'b0;
          if (pwdata[rims_pkg::STS_OVF_BIT])  state_next.ovf[p]  = 1'b0;
        end
      end
    end

    // output stage: pending slot of a port moves here when free
    take = state_reg.ov && tx_ready;
    if (take) state_next.ov = 1'b0;
    load = !state_reg.ov || tx_ready;

    for (int p = 0; p < 2; p++) begin
      state_next.ck_s1[p] = forward_pixel_clock[p];
      state_next.ck_s2[p] = state_reg.ck_s1[p];
      state_next.ck_prev[p] = state_reg.ck_s2[p];
      state_next.d_s1[p] = rx_frame[p];
      state_next.d_s2[p] = state_reg.d_s1[p];
      edge_seen = state_reg.ck_s2[p] && !state_reg.ck_prev[p];
      d  = state_reg.d_s2[p];
      m  = state_reg.cfg[p][1:0];
      hs = d[12];
      vs = d[13];
      if (edge_seen && state_reg.pd_s2) begin
        if (m != rims_pkg::MODE_CSI) begin
          state_next.hs_prev[p] = hs;
          state_next.vs_prev[p] = vs;
          sync_chg = (hs != state_reg.hs_prev[p]) ||
                     (vs != state_reg.vs_prev[p]);
          if (sync_chg) begin
            state_next.gap[p] = 4'h0;
            if (m == rims_pkg::MODE_RAW10 &&
                state_reg.gap[p] < 4'(rims_pkg::SYNC_GAP_PCLK - 1))
              state_next.viol[p] = 1'b1;
          end else if (state_reg.gap[p] != 4'hF) begin
            state_next.gap[p] = state_reg.gap[p] + 4'h1;
          end
        end
        if (state_reg.pv[p] && !(load && state_reg.rr == 1'(p))) begin
          state_next.ovf[p] = 1'b1;
        end else begin
          state_next.pv[p] = 1'b1;
          if (m == rims_pkg::MODE_CSI) begin
            // 40-bit frame: vc[39:38] dt[37:32] payload[31:0]
            state_next.pkind[p] = rims_pkg::RIMS_PK_CSI;
            state_next.pvc[p]   =
              state_reg.remap[p][2*d[39:38] +: 2];
            state_next.pdt[p]   = d[37:32];
            state_next.pdat[p]  = d[31:0];
          end else begin
            // 28-bit frame: vs[13] hs[12] pixel[11:0]
            state_next.pvc[p] = state_reg.hdr[p][7:6];
            state_next.pdt[p] = state_reg.hdr[p][5:0];
            if (vs && !state_reg.vs_prev[p])
              state_next.pkind[p] = rims_pkg::RIMS_PK_FS;
            else if (!vs && state_reg.vs_prev[p])
              state_next.pkind[p] = rims_pkg::RIMS_PK_FE;
            else if (hs && !state_reg.hs_prev[p])
              state_next.pkind[p] = rims_pkg::RIMS_PK_LS;
            else if (!hs && state_reg.hs_prev[p])
              state_next.pkind[p] = rims_pkg::RIMS_PK_LE;
            else
              state_next.pkind[p] = rims_pkg::RIMS_PK_PAYLOAD;
            state_next.pv[p] = (hs && vs) || sync_chg;
            state_next.pdat[p] = 32'h0000_0000;
            if (m == rims_pkg::MODE_RAW10) begin
              if (!state_reg.cfg[p][rims_pkg::CFG_RAW8_BIT])
                state_next.pdat[p][9:0] = d[9:0];
              else if (state_reg.cfg[p][rims_pkg::CFG_RAW8_LSB_BIT])
                state_next.pdat[p][7:0] = d[7:0];
              else
                state_next.pdat[p][7:0] = d[9:2];
            end else begin
              state_next.pdat[p][11:0] = d[11:0];
            end
          end
        end
      end
    end

    // round robin between ports; output is CSI-2 packets only
    pick = state_reg.pv;
    if (load && pick != 2'h0) begin
      state_next.rr = (pick == 2'h3) ? !state_reg.rr : pick[1];
      if (state_next.rr == state_reg.rr || pick != 2'h3) begin
        state_next.rr = pick[1] && !(pick[0] && !state_reg.rr);
      end
      state_next.ov    = 1'b1;
      state_next.oport = state_next.rr;
      state_next.okind = state_reg.pkind[state_next.rr];
      state_next.ovc   = state_reg.pvc[state_next.rr];
      state_next.odt   = state_reg.pdt[state_next.rr];
      state_next.odat  = state_reg.pdat[state_next.rr];
      if (!(edge_seen && state_reg.pd_s2 &&
            state_next.rr == 1'b1 && state_reg.pv[1]))
        state_next.pv[state_next.rr] = 1'b0;
    end

    if (setup) begin
      state_next.rdata = rd_mux;
      state_next.err   = !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg         <= '0;
      state_reg.pll_ctl <= rims_pkg::PLL_CTL_RST;
      state_reg.cfg     <= {rims_pkg::PORT_CFG_RST, rims_pkg::PORT_CFG_RST};
      state_reg.remap   <= {rims_pkg::VC_REMAP_RST, rims_pkg::VC_REMAP_RST};
      state_reg.hdr     <= {rims_pkg::RAW_HDR_RST, rims_pkg::RAW_HDR_RST};
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata        = state_reg.rdata;
  assign pslverr       = psel && penable && state_reg.err;
  assign tx_valid      = state_reg.ov;
  assign tx_port       = state_reg.oport;
  assign tx_kind       = state_reg.okind;
  assign tx_vc         = state_reg.ovc;
  assign tx_dt         = state_reg.odt;
  assign tx_data       = state_reg.odat;
  assign strap_mode    = state_reg.strap;
  assign strap_done    = state_reg.done;
  assign sync_clk_mode = state_reg.sync_clk;
  // synchronous mode: back channel twice reference; else fixed 10 Mbps
  assign back_rate     = state_reg.sync_clk ? rims_pkg::BC_MULT_SYNC
                                            : rims_pkg::BC_MBPS_NSYNC;
  assign pix_clk_mult  = state_reg.sync_clk ? rims_pkg::PCLK_MULT_SYNC
                                            : 8'h00;
endmodule : rims_top

// ### rims_top_assertions.sv
// checker for the mode-select block, bound to its top module.
// assumes the bench holds mode_strap steady across each strap sample.
`timescale 1ns/10ps
module rims_top_checker #(
  parameter int STRAP_WAIT = rims_pkg::STRAP_WAIT_CYC
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        power_down_n,
  input wire logic [2:0]  mode_strap,
  input wire logic        tx_ready,
  input wire logic        tx_valid,
  input wire logic        tx_port,
  input wire logic [2:0]  tx_kind,
  input wire logic [1:0]  tx_vc,
  input wire logic [5:0]  tx_dt,
  input wire logic [31:0] tx_data,
  input wire logic [2:0]  strap_mode,
  input wire logic        strap_done,
  input wire logic        sync_clk_mode,
  input wire logic [5:0]  back_rate,
  input wire logic [7:0]  pix_clk_mult
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  int   pd_cnt_reg;
  assign mapped = paddr[9:2] inside {8'h04, 8'h1F, 8'h6D, 8'h6E,
                                     [8'h70:8'h75]};
  // saturating count of cycles since the power-down pin went high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pd_cnt_reg <= 0;
    else if (!power_down_n) pd_cnt_reg <= 0;
    else if (pd_cnt_reg < STRAP_WAIT + 9) pd_cnt_reg <= pd_cnt_reg + 1;
  end
  sequence apb_access; psel && penable; endsequence
  sequence tx_stall; tx_valid && !tx_ready; endsequence
  sequence pd_steady; power_down_n [*4]; endsequence
  a_zero_wait: assert property (apb_access |-> pready)
    else $error("access phase without ready");
  a_mapped_ok: assert property (apb_access ##0 mapped |-> !pslverr)
    else $error("mapped register refused");
  a_unmapped_err: assert property (
    apb_access ##0 (!pwrite && !mapped) |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  a_strap_early: assert property (
    $rose(strap_done) |-> pd_cnt_reg >= STRAP_WAIT)
    else $error("strap sampled too soon");
  a_strap_late: assert property (
    pd_cnt_reg == STRAP_WAIT + 8 |-> strap_done)
    else $error("strap not sampled in time");
  a_strap_sample: assert property (
    $rose(strap_done) |-> strap_mode == mode_strap)
    else $error("strap level not captured");
  a_strap_clock: assert property ($rose(strap_done) |=>
    sync_clk_mode == (strap_mode == rims_pkg::STRAP_CSI_SYNC))
    else $error("clock mode not taken from strap");
  a_strap_hold: assert property (
    pd_steady ##0 strap_done |=> strap_done && $stable(strap_mode))
    else $error("strap result lost while powered");
  a_clock_rates: assert property (
    strap_done && $past(strap_done) && $stable(sync_clk_mode) |->
    (sync_clk_mode ? (back_rate == rims_pkg::BC_MULT_SYNC &&
                      pix_clk_mult == rims_pkg::PCLK_MULT_SYNC)
                   : (back_rate == rims_pkg::BC_MBPS_NSYNC &&
                      pix_clk_mult == 8'h00)))
    else $error("rates disagree with clock mode");
  a_tx_hold: assert property (tx_stall |=> tx_valid &&
    $stable({tx_port, tx_kind, tx_vc, tx_dt, tx_data}))
    else $error("packet changed while stalled");
  a_tx_kind: assert property (tx_valid |-> tx_kind <= 3'h5)
    else $error("packet kind out of range");
endmodule : rims_top_checker
bind rims_top rims_top_checker #(.STRAP_WAIT(STRAP_WAIT)) chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .power_down_n(power_down_n),
  .mode_strap(mode_strap), .tx_ready(tx_ready), .tx_valid(tx_valid),
  .tx_port(tx_port), .tx_kind(tx_kind), .tx_vc(tx_vc), .tx_dt(tx_dt),
  .tx_data(tx_data), .strap_mode(strap_mode), .strap_done(strap_done),
  .sync_clk_mode(sync_clk_mode), .back_rate(back_rate),
  .pix_clk_mult(pix_clk_mult)
);

// ### rims_top_test.sv
// self-checking bench: APB master, strap sweep, CSI and RAW traffic.
// assumes a shortened strap wait and the serializer model as far side.
`timescale 1ns/10ps
module rims_top_test;
  localparam int SW = 50;
  logic              pclk, presetn, psel, penable, pwrite, pslverr, pready;
  logic              power_down_n, tx_ready, tx_valid, tx_port;
  logic              strap_done, sync_clk_mode;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, tx_data;
  logic [3:0]        pstrb;
  logic [2:0]        mode_strap, tx_kind, strap_mode;
  logic [1:0]        tx_vc, fpc;
  logic [5:0]        tx_dt, back_rate;
  logic [7:0]        pix_clk_mult;
  logic [1:0][39:0]  frm;
  int                failures, n_compared;
  rims_top #(.STRAP_WAIT(SW)) rims_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_down_n(power_down_n), .mode_strap(mode_strap),
    .forward_pixel_clock(fpc), .rx_frame(frm), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_port(tx_port), .tx_kind(tx_kind),
    .tx_vc(tx_vc), .tx_dt(tx_dt), .tx_data(tx_data),
    .strap_mode(strap_mode), .strap_done(strap_done),
    .sync_clk_mode(sync_clk_mode), .back_rate(back_rate),
    .pix_clk_mult(pix_clk_mult));
  rims_ser_model rims_ser_model_inst (.forward_pixel_clock(fpc),
                                      .rx_frame(frm));
  always #10 pclk = ~pclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, input logic [3:0] st,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    pstrb  <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd,
                    input logic [3:0] st = 4'hF);
    logic [31:0] d;
    logic        e;
    apb(1'b1, idx, wd, st, d, e);
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [31:0] mask,
                     input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    apb(1'b0, idx, 32'h0, 4'h0, d, e);
    chk({31'h0, e}, 32'h0);
    chk(d & mask, exp);
  endtask : rdc
  task automatic get_pkt(input logic p, input logic [2:0] k,
                         input logic [1:0] vc, input logic [5:0] dt,
                         input logic [31:0] dat, input logic [31:0] dm);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!(tx_valid === 1'b1 && tx_ready === 1'b1) && n < 100);
    chk({31'h0, tx_valid & tx_ready}, 32'h1);
    chk({20'h0, tx_kind, tx_port, tx_vc, tx_dt}, {20'h0, k, p, vc, dt});
    chk(tx_data & dm, dat);
  endtask : get_pkt
  function automatic logic [31:0] exp_lr(input logic [2:0] code);
    case (code)
      3'h1:    return 32'h0;
      3'h2:    return 32'h38;
      3'h3:    return 32'h2A;
      3'h4:    return 32'h1E0;
      default: return 32'hF0;
    endcase
  endfunction : exp_lr
  task automatic t_reset_regs;
    logic [31:0] d;
    logic        e;
    rdc(rims_pkg::IDX_PORT_CFG0, 32'hFF, 32'h0);
    rdc(rims_pkg::IDX_CSI_PLL_CONTROL, 32'hFF, 32'h0);
    rdc(rims_pkg::IDX_VC_REMAP1, 32'hFF, 32'hE4);
    rdc(rims_pkg::IDX_RAW_HDR0, 32'hFF, 32'h2B);
    apb(1'b0, 8'h10, 32'h0, 4'h0, d, e);
    chk({31'h0, e}, 32'h1);
    chk(d, 32'h0);
  endtask : t_reset_regs
  task automatic t_strap(input logic [2:0] code);
    logic       s;
    int         n;
    s = (code == 3'h4);
    @(posedge pclk);
    mode_strap   <= code;
    power_down_n <= 1'b0;
    repeat (6) @(posedge pclk);
    power_down_n <= 1'b1;
    n = 0;
    while (strap_done !== 1'b1 && n < SW + 40) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, n >= SW && n < SW + 40}, 32'h1);
    chk({29'h0, strap_mode}, {29'h0, code});
    rdc(rims_pkg::IDX_PORT_CFG0, 32'h3,
        code > 3'h3 ? 32'h0 : {29'h0, code});
    rdc(rims_pkg::IDX_PORT_CFG1, 32'h3,
        code > 3'h3 ? 32'h0 : {29'h0, code});
    rdc(rims_pkg::IDX_DEVICE_STATUS, 32'h10, {27'h0, s, 4'h0});
    rdc(rims_pkg::IDX_CSI_PLL_CONTROL, 32'h3, {31'h0, s});
    rdc(rims_pkg::IDX_PORT_STS0, 32'h1FF, exp_lr(code));
    chk({18'h0, back_rate, pix_clk_mult},
        s ? 32'h0204 : 32'h0A00);
  endtask : t_strap
  task automatic t_override;
    wr(rims_pkg::IDX_PORT_CFG1, 32'h3);
    rdc(rims_pkg::IDX_PORT_CFG0, 32'h3, 32'h0);
    rdc(rims_pkg::IDX_PORT_CFG1, 32'h3, 32'h3);
    rdc(rims_pkg::IDX_PORT_STS1, 32'h1FF, 32'h2A);
    wr(rims_pkg::IDX_CSI_PLL_CONTROL, 32'h1);
    rdc(rims_pkg::IDX_DEVICE_STATUS, 32'h10, 32'h10);
    rdc(rims_pkg::IDX_PORT_STS0, 32'h1FF, 32'h1E0);
    chk({30'h0, sync_clk_mode, back_rate == 6'h2}, 32'h3);
    wr(rims_pkg::IDX_CSI_PLL_CONTROL, 32'h0);
  endtask : t_override
  task automatic t_csi;
    int n;
    wr(rims_pkg::IDX_VC_REMAP0, 32'hEC);
    tx_ready <= 1'b0;
    rims_ser_model_inst.send(0, {2'h1, 6'h2A, 32'hA5C30F12});
    n = 0;
    while (tx_valid !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    repeat (3) @(posedge pclk);
    chk({31'h0, tx_valid}, 32'h1);
    tx_ready <= 1'b1;
    get_pkt(1'b0, 3'h5, 2'h3, 6'h2A, 32'hA5C30F12, '1);
    rdc(rims_pkg::IDX_PORT_STS0, 32'h800, 32'h800);
  endtask : t_csi
  task automatic t_raw;
    wr(rims_pkg::IDX_RAW_HDR1, 32'h6C);
    fork
      rims_ser_model_inst.send_raw(1, 1'b1, 1'b0, 12'h155);
      get_pkt(1'b1, 3'h1, 2'h1, 6'h2C, 32'h0, 32'h0);
    join
    // clear the violation flag left by the first transition
    wr(rims_pkg::IDX_PORT_STS1, 32'h200, 4'h2);
    fork
      rims_ser_model_inst.send_raw(1, 1'b1, 1'b1, 12'h2AB);
      get_pkt(1'b1, 3'h3, 2'h1, 6'h2C, 32'h0, 32'h0);
    join
    rdc(rims_pkg::IDX_PORT_STS1, 32'h200, 32'h200);
    wr(rims_pkg::IDX_PORT_STS1, 32'h200, 4'h2);
    rdc(rims_pkg::IDX_PORT_STS1, 32'hA00, 32'h0);
    fork
      rims_ser_model_inst.send_raw(1, 1'b1, 1'b1, 12'h3C5);
      get_pkt(1'b1, 3'h0, 2'h1, 6'h2C, 32'h3C5, '1);
    join
    // raw8 inside raw10: upper eight bits, then lower eight bits
    for (int v = 0; v < 2; v++) begin
      wr(rims_pkg::IDX_PORT_CFG1, v ? 32'hF : 32'h7);
      fork
        rims_ser_model_inst.send_raw(1, 1'b1, 1'b1, 12'h3C5);
        get_pkt(1'b1, 3'h0, 2'h1, 6'h2C, v ? 32'hC5 : 32'hF1, '1);
      join
    end
  endtask : t_raw
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    power_down_n = 1'b0;
    mode_strap = 3'h0;
    tx_ready = 1'b1;
    failures = 0;
    n_compared = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_regs;
    for (int c = 7; c >= 0; c--) t_strap(3'(c));
    t_override;
    t_csi;
    t_raw;
    report_and_stop;
  end
  initial begin
    #1_000_000;
    failures++;
    report_and_stop;
  end
endmodule : rims_top_test
